//--- hdl/cell_pkg.sv
// package for the configurable logic cell: register map, field layouts,
// reset values, selector codes and the memory mode enumeration.
// assumes a 32-bit register port with byte offsets on an 8-bit address.
package cell_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] CFG_OFS  = 8'h00;  // cell configuration word
  localparam logic [7:0] LUTF_OFS = 8'h04;  // first table contents
  localparam logic [7:0] LUTG_OFS = 8'h08;  // second table contents
  localparam logic [7:0] LUTH_OFS = 8'h0c;  // third table and output selects
  localparam logic [7:0] STAT_OFS = 8'h10;  // live cell state, read only

  //////////////////////////////////////////////////////////////////////////////
  // widths and reset values
  localparam int unsigned LUT4_W = 16;
  localparam int unsigned LUTH_W = 12;
  localparam logic [31:0]       CFG_RST   = 32'h0000_0000;
  localparam logic [LUT4_W-1:0] LUT4_RST  = 16'h0000;
  localparam logic [LUTH_W-1:0] LUTH_RST  = 12'h000;
  localparam logic [31:0]       RD_IDLE   = 32'h0000_0000;

  // fields of the third-table register above its eight truth-table bits
  localparam int unsigned LUTH_TBL_MSB = 7;
  localparam int unsigned H0_FROM_F    = 8;   // third-table input zero from F'
  localparam int unsigned H2_FROM_G    = 9;   // third-table input two from G'
  localparam int unsigned X_FROM_H     = 10;  // first comb output shows H'
  localparam int unsigned Y_FROM_H     = 11;  // second comb output shows H'

  // internal control roles, index into the role selector array
  localparam int unsigned ROLE_EC  = 0;  // storage clock enable
  localparam int unsigned ROLE_SR  = 1;  // set/clear, H0, or write enable
  localparam int unsigned ROLE_DIN = 2;  // direct in, H2, or data bit zero
  localparam int unsigned ROLE_H1  = 3;  // H1, or data bit one / address bit 4

  // storage element data source codes
  localparam logic [1:0] DSEL_F   = 2'h0;
  localparam logic [1:0] DSEL_G   = 2'h1;
  localparam logic [1:0] DSEL_H   = 2'h2;
  localparam logic [1:0] DSEL_DIN = 2'h3;

  // memory arrangement of the two four-input tables
  typedef enum logic [2:0] {
    MEM_LOGIC = 3'b000,  // both tables are logic
    MEM_F16   = 3'b001,  // first table 16x1, second table logic
    MEM_16X2  = 3'b010,  // two 16x1 memories, own data in and out
    MEM_32X1  = 3'b011,  // one 32x1 memory, data bit one is address bit 4
    MEM_DUAL  = 3'b100   // one 16x1 memory, one write and two read ports
  } mem_mode_t;

  // configuration word, msb first; per-element fields index 0 = X, 1 = Y
  typedef struct packed {
    logic                 gsr_inv;   // global set/reset active low
    logic                 wclk_inv;  // memory writes on the falling edge
    logic                 level;     // level-sensitive write timing
    mem_mode_t            mode;
    logic [1:0][1:0]      bsel;      // control input used by the bypass
    logic [1:0]           byp;       // registered output shows bypass
    logic [1:0]           ecu;       // clock enable connected
    logic [1:0]           cinv;      // storage element on falling edge
    logic [1:0]           sren;      // local set/clear connected
    logic [1:0]           set;       // configured state is 1
    logic [1:0][1:0]      dsel;      // storage data source
    logic [3:0][1:0]      role;      // control input feeding each role
  } cfg_t;

  // status word
  typedef struct packed {
    logic [25:0] pad;
    logic        gsr_act;
    logic        clk_lvl;
    logic        x_comb;
    logic        y_comb;
    logic [1:0]  q;
  } stat_t;

  localparam logic [25:0] STAT_PAD = 26'h0000000;

endpackage : cell_pkg

//--- hdl/logic_cell.sv
// logic cell: two four-input tables usable as memory, a third table, two
// storage elements with global and local set/clear, control role routing.
// assumes table and control inputs come from logic on CLK_SYS; the cell
// clock and global set/reset pins are asynchronous and are synchronised.

`timescale 1ns/1ps

module logic_cell
  import cell_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  input  wire logic        CELL_CLK,
  input  wire logic        GLOBAL_SET_RESET,
  input  wire logic [3:0]  CELL_CONTROL_INPUTS,
  input  wire logic [3:0]  FIRST_TABLE_INPUTS,
  input  wire logic [3:0]  SECOND_TABLE_INPUTS,
  input  wire logic [3:0]  SECOND_READ_ADDRESS,
  output logic             FIRST_COMB_OUT,
  output logic             SECOND_COMB_OUT,
  output logic             FIRST_REGISTERED_OUT,
  output logic             SECOND_REGISTERED_OUT
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic lut4(input logic [LUT4_W-1:0] tbl, input logic [3:0] idx);
    return tbl[idx];
  endfunction : lut4

  function automatic logic pick_edge(input logic rise, input logic fall, input logic inv);
    return inv ? fall : rise;
  endfunction : pick_edge

  function automatic logic at(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction : at

  //////////////////////////////////////////////////////////////////////////////
  // state

  cfg_t              cfg;
  logic [LUT4_W-1:0] lut_f;
  logic [LUT4_W-1:0] lut_g;
  logic [LUTH_W-1:0] lut_h;
  logic [2:0]        clk_sync;
  logic [2:0]        gsr_sync;
  logic              clk_lvl;
  logic              gsr_lvl;
  logic              reconfig;
  logic [1:0]        q;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once the second and third stages agree

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      clk_sync <= 3'h0;
      gsr_sync <= 3'h0;
    end else begin
      clk_sync <= {clk_sync[1:0], CELL_CLK};
      gsr_sync <= {gsr_sync[1:0], GLOBAL_SET_RESET};
    end
  end

  // filtered levels; a glitch seen by only one stage never counts
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      clk_lvl <= 1'b0;
      gsr_lvl <= 1'b0;
    end else begin
      if (clk_sync[1] == clk_sync[2]) clk_lvl <= clk_sync[2];
      if (gsr_sync[1] == gsr_sync[2]) gsr_lvl <= gsr_sync[2];
    end
  end

  wire clk_agree = (clk_sync[1] == clk_sync[2]);
  wire clk_rise  = clk_agree & clk_sync[2] & ~clk_lvl;
  wire clk_fall  = clk_agree & ~clk_sync[2] & clk_lvl;
  wire gsr_act   = gsr_lvl ^ cfg.gsr_inv;

  //////////////////////////////////////////////////////////////////////////////
  // register port decode

  wire sel_cfg  = at(REG_ADDR, CFG_OFS);
  wire sel_lutf = at(REG_ADDR, LUTF_OFS);
  wire sel_lutg = at(REG_ADDR, LUTG_OFS);
  wire sel_luth = at(REG_ADDR, LUTH_OFS);
  wire sel_stat = at(REG_ADDR, STAT_OFS);
  wire cfg_wr   = REG_WR & sel_cfg;
  wire bus_wf   = REG_WR & sel_lutf;
  wire bus_wg   = REG_WR & sel_lutg;

  //////////////////////////////////////////////////////////////////////////////
  // control role routing

  logic [3:0] role_val;
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_role
      assign role_val[k] = CELL_CONTROL_INPUTS[cfg.role[k]];
    end
  endgenerate

  // the same wires, all but ec, take memory meanings once a table is memory
  wire mem_on   = (cfg.mode == MEM_F16) | (cfg.mode == MEM_16X2) |
                  (cfg.mode == MEM_32X1) | (cfg.mode == MEM_DUAL);
  wire ec       = role_val[ROLE_EC];
  wire sr_h0    = role_val[ROLE_SR];
  wire din_h2   = role_val[ROLE_DIN];
  wire h1       = role_val[ROLE_H1];
  wire we       = mem_on & sr_h0;
  wire d0       = din_h2;
  wire d1       = h1;

  //////////////////////////////////////////////////////////////////////////////
  // memory write control
  // one timing bit serves the whole cell, so the two tables cannot disagree

  wire is_32    = (cfg.mode == MEM_32X1);
  wire is_16x2  = (cfg.mode == MEM_16X2);
  wire is_dual  = (cfg.mode == MEM_DUAL);
  wire lvl_mode = cfg.level & ~is_dual;
  wire wclk_edge = pick_edge(clk_rise, clk_fall, cfg.wclk_inv);
  wire wr_strobe = we & (lvl_mode | wclk_edge);
  wire wr_f     = wr_strobe & ((cfg.mode == MEM_F16) | is_16x2 | is_dual | (is_32 & ~d1));
  wire wr_g     = wr_strobe & (is_16x2 | is_dual | (is_32 & d1));
  wire data_g   = is_16x2 ? d1 : d0;

  // addresses: 32x1 shares the first address, dual port writes by it too
  wire [3:0] fa     = FIRST_TABLE_INPUTS;
  wire [3:0] ga     = is_32 ? fa : SECOND_TABLE_INPUTS;
  wire [3:0] g_wadr = is_dual ? fa : ga;
  wire [3:0] g_radr = is_dual ? SECOND_READ_ADDRESS : ga;

  // table storage; a bus load wins over a user write in the same cycle
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      lut_f <= LUT4_RST;
      lut_g <= LUT4_RST;
    end else begin
      if (bus_wf) lut_f <= REG_WDATA[LUT4_W-1:0];
      else if (wr_f) lut_f[fa] <= d0;
      if (bus_wg) lut_g <= REG_WDATA[LUT4_W-1:0];
      else if (wr_g) lut_g[g_wadr] <= data_g;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reads: plain table lookup; 32x1 takes F' from the second table when data bit one is high, dual port reads G' at SECOND_READ_ADDRESS

  wire f_raw   = lut4(lut_f, fa);
  wire g_prime = lut4(lut_g, g_radr);
  wire f_prime = (is_32 & d1) ? lut4(lut_g, fa) : f_raw;

  // third table: in memory modes it sees F', G' and data bit one
  wire h0_in   = (mem_on | lut_h[H0_FROM_F]) ? f_prime : sr_h0;
  wire h2_in   = (mem_on | lut_h[H2_FROM_G]) ? g_prime : din_h2;
  wire [2:0] h_idx = {h2_in, h1, h0_in};
  wire h_prime = lut_h[h_idx];

  // comb outputs carry memory data straight out, no flop on the path
  assign FIRST_COMB_OUT  = lut_h[X_FROM_H] ? h_prime : f_prime;
  assign SECOND_COMB_OUT = lut_h[Y_FROM_H] ? h_prime : g_prime;

  //////////////////////////////////////////////////////////////////////////////
  // reconfiguration pulse: forcing waits a cycle so the new set bits apply

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) reconfig <= 1'b0;
    else        reconfig <= cfg_wr;
  end

  //////////////////////////////////////////////////////////////////////////////
  // storage elements

  logic [1:0] d_val;
  logic [1:0] frc;
  logic [1:0] ce;
  logic [1:0] load;
  logic [1:0] next_q;
  logic [1:0] reg_out;
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_store
      // set/clear line is the write enable in memory modes, so it is ignored there
      wire lsr  = cfg.sren[i] & ~mem_on & sr_h0;
      wire edg  = pick_edge(clk_rise, clk_fall, cfg.cinv[i]);
      assign ce[i]    = ~cfg.ecu[i] | ec;
      assign frc[i]   = gsr_act | reconfig | lsr;
      assign load[i]  = ~frc[i] & edg & ce[i];
      assign d_val[i] = (cfg.dsel[i] == DSEL_F) ? f_prime :
                        (cfg.dsel[i] == DSEL_G) ? g_prime :
                        (cfg.dsel[i] == DSEL_H) ? h_prime : din_h2;
      assign next_q[i] = frc[i] ? cfg.set[i] : load[i] ? d_val[i] : q[i];
      assign reg_out[i] = cfg.byp[i] ? CELL_CONTROL_INPUTS[cfg.bsel[i]] : q[i];
    end
  endgenerate

  // reset value 0 equals the clear state of the reset configuration
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) q <= 2'h0;
    else        q <= next_q;
  end

  assign FIRST_REGISTERED_OUT  = reg_out[0];
  assign SECOND_REGISTERED_OUT = reg_out[1];

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cfg   <= cfg_t'(CFG_RST);
      lut_h <= LUTH_RST;
    end else begin
      if (cfg_wr) cfg <= cfg_t'(REG_WDATA);
      if (REG_WR && sel_luth) lut_h <= REG_WDATA[LUTH_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data: stands only in the cycle after the strobe, else zero

  stat_t stat;
  assign stat = '{pad: STAT_PAD, gsr_act: gsr_act, clk_lvl: clk_lvl,
                  x_comb: FIRST_COMB_OUT, y_comb: SECOND_COMB_OUT, q: q};

  logic [31:0] rd_mux;
  assign rd_mux = sel_cfg  ? 32'(cfg) :
                  sel_lutf ? 32'(lut_f) :
                  sel_lutg ? 32'(lut_g) :
                  sel_luth ? 32'(lut_h) :
                  sel_stat ? 32'(stat) : RD_IDLE;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) REG_RDATA <= RD_IDLE;
    else        REG_RDATA <= REG_RD ? rd_mux : RD_IDLE;
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  AST_GSR_FORCE: assert property (gsr_act |=> q == $past(cfg.set))
    else $error("global set/reset did not force configured state");

  AST_RECONFIG: assert property (cfg_wr |=> ##1 q == $past(cfg.set))
    else $error("reconfiguration did not force configured state");

  AST_LOCAL_SR: assert property ((cfg.sren[0] && !mem_on && sr_h0) |=> q[0] == $past(cfg.set[0]))
    else $error("local set/clear gave the wrong state");

  AST_GSR_POL: assert property ((gsr_lvl && cfg.gsr_inv && !reconfig && !sr_h0 && !load[1]) |=> $stable(q[1]))
    else $error("inverted global set/reset acted while high");

  AST_DATA_SEL: assert property (load[0] |=> q[0] == $past(d_val[0]))
    else $error("storage element loaded the wrong source");

  AST_EC_HOLD: assert property ((!frc[1] && cfg.ecu[1] && !ec) |=> $stable(q[1]))
    else $error("storage element changed with clock enable low");

  AST_EDGE_WRITE: assert property ((is_16x2 && !lvl_mode && we && wclk_edge && !bus_wf)
                                   |=> lut_f[$past(fa)] == $past(d0))
    else $error("edge write did not store data bit zero");

  AST_NO_STRAY_WRITE: assert property ((mem_on && !lvl_mode && !wclk_edge && !bus_wf && !bus_wg)
                                       |=> $stable(lut_f) && $stable(lut_g))
    else $error("memory changed without a write edge");

  AST_LEVEL_WRITE: assert property ((cfg.mode == MEM_F16 && lvl_mode && we && !bus_wf)
                                    |=> lut_f[$past(fa)] == $past(d0))
    else $error("level write missed while write enable high");

  AST_DUAL_EDGE_ONLY: assert property ((is_dual && cfg.level && we && !wclk_edge && !bus_wg)
                                       |=> $stable(lut_g))
    else $error("dual port wrote without an edge");

  AST_DUAL_BOTH: assert property ((is_dual && we && wclk_edge && !bus_wf && !bus_wg)
                                  |=> lut_f[$past(fa)] == $past(d0) && lut_g[$past(fa)] == $past(d0))
    else $error("dual port write missed a table");

  AST_READ_AFTER_WRITE: assert property ((is_dual && wr_f && !bus_wf && !bus_wg) ##1
                                         (is_dual && SECOND_READ_ADDRESS == $past(fa))
                                         |-> g_prime == $past(d0))
    else $error("second read port missed the new value");

  AST_32_UPPER: assert property ((is_32 && wr_strobe && d1 && !bus_wf) |=> $stable(lut_f))
    else $error("upper half write touched the first table");

  COV_DUAL_WRITE: cover property (is_dual && wr_strobe);
  COV_32_UPPER:   cover property (is_32 && wr_strobe && d1);
  COV_GSR:        cover property (gsr_act ##1 !gsr_act);
  COV_LOAD:       cover property (load[0] ##1 load[1]);

endmodule : logic_cell

//--- tb/cell_clk_model.sv
// user logic model that drives the cell clock pin with one full pulse per request
// assumes CLK_SYS from the bench; go is a one-cycle request taken while idle
`timescale 1ns/1ps

module cell_clk_model (
  input  wire logic CLK_SYS,
  input  wire logic go,
  output logic      cell_clk,
  output logic      busy
);
  logic [3:0] cnt = 4'h0;

  //////////////////////////////////////////////////////////////////////////////
  // six cycles high then six low: the pin is synchronised, so shorter phases could be lost
  assign busy     = (cnt != 4'h0);
  assign cell_clk = (cnt > 4'h6);  // stands still low between pulses

  // countdown of one pulse
  always @(posedge CLK_SYS) begin
    if (go && cnt == 4'h0)
      cnt <= 4'hc;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
  end
endmodule : cell_clk_model

//--- tb/logic_cell_storage_and_lut_ram_bench.sv
// self-checking bench for the logic cell: register port, tables, storage, memory modes
// assumes cell_pkg and the cell clock model; reads and pin samples are checked from queues
`timescale 1ns/1ps

module logic_cell_storage_and_lut_ram_bench import cell_pkg::*;;
  logic        clk_sys   = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        global_set_reset       = 1'b0;
  logic        go        = 1'b0;
  logic [3:0]  fa = 4'h0, ga = 4'h0, ctl = 4'h0, second_read_address = 4'h0;
  logic [31:0] reg_rdata, r;
  logic        cell_clk, busy, xo, yo, xq, yq, xe;
  logic        rd_q = 1'b0, pin_chk = 1'b0;
  logic [31:0] rq[$];
  logic [7:0]  pq[$];
  logic [7:0]  p;
  logic [15:0] lf, lg;
  logic [11:0] lh;
  logic [3:0]  a, b, k;
  logic [1:0]  kk;
  cfg_t        c;
  mem_mode_t   mm [2] = '{MEM_F16, MEM_16X2};
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #20 clk_sys = ~clk_sys;

  logic_cell uut (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CELL_CLK(cell_clk),
    .GLOBAL_SET_RESET(global_set_reset), .CELL_CONTROL_INPUTS(ctl), .FIRST_TABLE_INPUTS(fa),
    .SECOND_TABLE_INPUTS(ga), .SECOND_READ_ADDRESS(second_read_address), .FIRST_COMB_OUT(xo),
    .SECOND_COMB_OUT(yo), .FIRST_REGISTERED_OUT(xq), .SECOND_REGISTERED_OUT(yq));

  cell_clk_model kmod (.CLK_SYS(clk_sys), .go(go), .cell_clk(cell_clk), .busy(busy));

  //////////////////////////////////////////////////////////////////////////////
  // comparison and report
  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected REG_RDATA expected %h seen %h", e, s);
    end
  endtask : cmp_rd

  task automatic cmp_pin(input logic [3:0] e, input logic [3:0] m, input logic [3:0] s);
    samples_checked++;
    if ((s & m) !== (e & m)) begin
      error_cnt++;
      $display("unexpected outputs xo yo xq yq expected %b seen %b mask %b", e, s, m);
    end
  endtask : cmp_pin

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // watcher: read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_q)
      cmp_rd(rq.pop_front(), reg_rdata);
    if (pin_chk) begin
      p = pq.pop_front();
      cmp_pin(p[3:0], p[7:4], {xo, yo, xq, yq});
    end
    rd_q <= reg_rd;
  end

  //////////////////////////////////////////////////////////////////////////////
  // drivers: everything changes right after a rising edge
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge clk_sys);
    rq.push_back(e);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd

  // a reconfiguration forces the storage a few cycles later, so let it settle
  task automatic cfg();
    wr(CFG_OFS, c);
    repeat (4) @(posedge clk_sys);
  endtask : cfg

  task automatic put(input logic [3:0] fi, input logic [3:0] gi, input logic [3:0] ci, input logic [3:0] di);
    @(posedge clk_sys);
    fa   <= fi;
    ga   <= gi;
    ctl  <= ci;
    second_read_address <= di;
  endtask : put

  task automatic pins(input logic [3:0] e, input logic [3:0] m);
    @(posedge clk_sys);
    pq.push_back({m, e});
    pin_chk <= 1'b1;
    @(posedge clk_sys);
    pin_chk <= 1'b0;
  endtask : pins

  // one cell clock pulse; busy is looked at on the falling edge where it has settled
  task automatic kclk();
    int n;
    n = 0;
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(negedge clk_sys);
    while (busy !== 1'b0 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : kclk

  // third table output with roles e4: h0 from C2, h2 from C3, h1 from C4
  function automatic logic hx(input logic [3:0] fi, input logic [3:0] gi, input logic [3:0] ci);
    logic h0, h2;
    h0 = lh[H0_FROM_F] ? lf[fi] : ci[1];
    h2 = lh[H2_FROM_G] ? lg[gi] : ci[2];
    return lh[{h2, ci[3], h0}];
  endfunction : hx

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    summarize();
  end

  initial begin
    r = $urandom(32'h5f93d9ae);
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset values, read-only status and an unmapped place
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
    wr(STAT_OFS, 32'hffffffff);
    wr(8'h14, 32'hffffffff);
    rd(STAT_OFS, 32'h0);
    rd(8'h14, 32'h0);
    pins(4'h0, 4'hf);
    // table contents and combinational outputs, H' routed in on some passes
    for (int j = 0; j < 3; j++) begin
      r = $urandom();
      lf = r[15:0];
      lg = r[31:16];
      r = $urandom();
      lh = r[11:0];
      wr(LUTF_OFS, {16'h0, lf});
      wr(LUTG_OFS, {16'h0, lg});
      wr(LUTH_OFS, {20'h0, lh});
      rd(LUTH_OFS, {20'h0, lh});
      c = '0;
      c.role = 8'he4;
      cfg();
      for (int i = 0; i < 16; i++) begin
        r = $urandom();
        put(4'(i), r[3:0], r[7:4], 4'h0);
        pins({lh[X_FROM_H] ? hx(4'(i), r[3:0], r[7:4]) : lf[i],
              lh[Y_FROM_H] ? hx(4'(i), r[3:0], r[7:4]) : lg[r[3:0]], 2'b00}, 4'b1100);
      end
    end
    // storage data source, direct input on the second element, enable left open and then connected
    c.dsel[1] = DSEL_DIN;
    for (int d = 0; d < 4; d++) begin
      c.dsel[0] = 2'(d);
      cfg();
      r = $urandom();
      {k, b, a} = r[11:0];
      put(a, b, k, 4'h0);
      kclk();
      xe = (d == 0) ? lf[a] : (d == 1) ? lg[b] : (d == 2) ? hx(a, b, k) : k[2];
      pins({2'b00, xe, k[2]}, 4'b0011);
    end
    c.ecu = 2'b11;
    cfg();
    put(a, b, 4'b0100, 4'h0);
    kclk();
    pins(4'h0, 4'b0011);
    put(a, b, 4'b0101, 4'h0);
    kclk();
    pins(4'b0011, 4'b0011);
    // bypass of each registered output to every control input
    c.byp = 2'b11;
    for (int i = 0; i < 4; i++) begin
      kk = 2'(i);
      c.bsel[0] = kk;
      c.bsel[1] = ~kk;
      cfg();
      r = $urandom();
      put(4'h0, 4'h0, r[3:0], 4'h0);
      pins({2'b00, r[kk], r[~kk]}, 4'b0011);
    end
    // global set/reset in both polarities, first element set, second cleared
    lg = 16'hffff;
    wr(LUTG_OFS, 32'h0000ffff);
    for (int g = 0; g < 2; g++) begin
      c = '0;
      c.role = 8'he4;
      c.gsr_inv = g[0];
      c.set = 2'b01;
      c.dsel[0] = DSEL_DIN;
      c.dsel[1] = DSEL_G;
      global_set_reset <= g[0];
      cfg();
      pins(4'b0010, 4'b0011);
      put(4'h0, 4'h0, 4'h0, 4'h0);
      kclk();
      pins(4'b0001, 4'b0011);
      global_set_reset <= ~g[0];
      repeat (6) @(posedge clk_sys);
      pins(4'b0010, 4'b0011);
      global_set_reset <= g[0];
      repeat (6) @(posedge clk_sys);
    end
    // edge-triggered memory: one table, then two; WE held without an edge must not write
    lh = 12'h000;
    wr(LUTH_OFS, 32'h0);
    foreach (mm[j]) begin
      c = '0;
      c.role = 8'he4;
      c.mode = mm[j];
      cfg();
      for (int i = 0; i < 6; i++) begin
        r = $urandom();
        {k, b, a} = {r[9:8], i[0], 1'b1, r[7:0]};
        put(a, b, k, 4'h0);
        repeat (8) @(posedge clk_sys);
        pins({lf[a], lg[b], 2'b00}, 4'b1100);
        kclk();
        if (i[0])
          lf[a] = k[2];
        if (i[0] && mm[j] == MEM_16X2)
          lg[b] = k[3];
        pins({lf[a], lg[b], 2'b00}, 4'b1100);
      end
    end
    rd(LUTF_OFS, {16'h0, lf});
    // level-sensitive memory: a one-cycle WE pulse shaped here writes with no edge
    c.level = 1'b1;
    cfg();
    for (int i = 0; i < 4; i++) begin
      r = $urandom();
      put(r[3:0], r[7:4], {r[9:8], 2'b01}, 4'h0);
      put(r[3:0], r[7:4], {r[9:8], 2'b11}, 4'h0);
      put(r[3:0], r[7:4], {r[9:8], 2'b01}, 4'h0);
      lf[r[3:0]] = r[8];
      lg[r[7:4]] = r[9];
      pins({lf[r[3:0]], lg[r[7:4]], 2'b00}, 4'b1100);
    end
    // dual port with level set: still edge only, write through primary address
    c.mode = MEM_DUAL;
    cfg();
    for (int i = 0; i < 6; i++) begin
      r = $urandom();
      // data bit zero random, enable on; write enable forced on just below
      {k, b, a} = {1'b0, r[8], 2'b01, i[0] ? r[3:0] : r[7:4], r[3:0]};
      k[1] = 1'b1;
      put(a, 4'h0, k, b);
      repeat (6) @(posedge clk_sys);
      pins({lf[a], lg[b], 2'b00}, 4'b1100);
      kclk();
      lf[a] = k[2];
      lg[a] = k[2];
      pins({lf[a], lg[b], 2'b00}, 4'b1100);
    end
    // 32x1: data bit one picks the table as the fifth address bit
    c.mode = MEM_32X1;
    c.level = 1'b0;
    cfg();
    for (int i = 0; i < 4; i++) begin
      r = $urandom();
      a = r[3:0];
      put(a, a, {i[0], r[8], 2'b11}, 4'h0);
      kclk();
      if (i[0])
        lg[a] = r[8];
      else
        lf[a] = r[8];
      pins({i[0] ? lg[a] : lf[a], 3'b000}, 4'b1000);
    end
    repeat (3) @(posedge clk_sys);
    summarize();
  end
endmodule : logic_cell_storage_and_lut_ram_bench
